// File: design/tpps_pkg.sv
// constants shared by the trace port pattern and status block
package tpps_pkg;

  // ==========================================================
  // register map (byte offsets on the axi4-lite slave)
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFF_MODE_SELECT = 5'h00;
  localparam logic [4:0] OFF_REPEAT_COUNT = 5'h04;
  localparam logic [4:0] OFF_FORMATTER_STATUS = 5'h08;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  // ==========================================================
  // mode select fields
  localparam int CONTINUOUS_MODE_ENABLE_BIT = 17;
  localparam int TIMED_MODE_ENABLE_BIT = 16;
  localparam int PAT_W = 4;
  localparam logic [1:0] WALKING_ONES_SEL = 2'h0;
  localparam logic [1:0] WALKING_ZEROS_SEL = 2'h1;
  localparam logic [1:0] ALTERNATING_AA_55_SEL = 2'h2;
  localparam logic [1:0] ALTERNATING_FF_ZERO_SEL = 2'h3;
  localparam logic [17:0] MODE_WRITE_MASK = 18'h3_000f;
  localparam logic [17:0] MODE_RESET = 18'h0_0000;

  // ==========================================================
  // repeat count and status fields
  localparam int PATTERN_CYCLE_COUNT_W = 8;
  localparam logic [7:0] REPEAT_COUNT_RESET = 8'h00;
  localparam int FLUSH_ACTIVE_BIT = 0;
  localparam int FORMATTER_HALTED_BIT = 1;
  localparam int CONTROL_PIN_PRESENT_BIT = 2;

  // ==========================================================
  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_TIMED_DONE = 0;
  localparam int IRQ_HALTED = 1;
  localparam int IRQ_FLUSH_DONE = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ==========================================================
  // bus answers, port width, write channel states
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned TRACE_PORT_W = 32;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HAVE_ADDR = 2'b01,
    WR_RESP = 2'b11,
    WR_HAVE_DATA = 2'b10
  } tpps_wr_e;

endpackage : tpps_pkg

// File: design/tpps_sync.sv
// two flip-flop synchroniser for levels from outside the aclk domain
`timescale 1ns/100ps
`default_nettype none
module tpps_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import tpps_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tpps_sync_s;

  tpps_sync_s q;
  tpps_sync_s d;

  // first stage feeds only the second stage
  always_comb begin
    d.meta = async_in;
    d.stable = q.meta;
  end

  // ==========================================================
  // stage registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;
endmodule : tpps_sync
`default_nettype wire

// File: design/tpps_patgen.sv
// word generator for the four trace port test patterns
`timescale 1ns/100ps
`default_nettype none
module tpps_patgen #(
  parameter int unsigned PORT_W = tpps_pkg::TRACE_PORT_W,
  parameter int unsigned STEP_W = 5
) (
  input wire logic [1:0] sel,
  input wire logic [STEP_W-1:0] step,
  input wire logic phase,
  output logic [PORT_W-1:0] word
);
  import tpps_pkg::*;

  // pattern word from selected pattern, bit position and phase
  always_comb begin
    case (sel)
      WALKING_ONES_SEL: word = PORT_W'(1) << step;
      WALKING_ZEROS_SEL: word = ~(PORT_W'(1) << step);
      ALTERNATING_AA_55_SEL: begin
        word = phase ? {(PORT_W/2){2'b01}} : {(PORT_W/2){2'b10}};
      end
      ALTERNATING_FF_ZERO_SEL: word = {PORT_W{~phase}};
      default: word = '0;
    endcase
  end
endmodule : tpps_patgen
`default_nettype wire

// File: design/tpps_top.sv
// trace port test pattern generator with formatter and flush status
// Operation
// - bit 17 continuous, bit 16 timed, at most one set; none means off
// - any mix of the four pattern enables runs, each one in turn
// - bit3 ff/00, bit2 aa/55, bit1 walking zeros, bit0 walking ones
// - timed mode turns itself off after its cycles, no write needed
// - mode select register resets to zero: off, no pattern
// - eight-bit repeat value loads a down counter run by the patterns
// - repeat register write sets start value; read gives programmed value
// - each pattern runs repeat-count trace clock cycles (one when the count is zero) then advances
// - repeat count register resets to zero
// - status bit 2 reads one when the control pin exists
// - status bit 1 reads one once the formatter has fully stopped
// - once stopped, trace input ready stays high and data is dropped
`timescale 1ns/100ps
`default_nettype none
module tpps_top #(
  parameter int unsigned PORT_W = tpps_pkg::TRACE_PORT_W,
  parameter bit CTL_PRESENT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tpps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tpps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic traceclkin,
  output logic [PORT_W-1:0] trace_data,
  output logic trace_control_pin,
  input wire logic trace_in_valid,
  output logic trace_in_ready,
  output logic fmt_in_valid,
  input wire logic fmt_in_ready,
  input wire logic fmt_stopped,
  input wire logic flush_request,
  output logic flush_valid,
  input wire logic flush_ready,
  output logic irq
);
  import tpps_pkg::*;

  localparam int unsigned STEP_W = $clog2(PORT_W);

  typedef struct packed {
    tpps_wr_e wr;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [17:0] mode;
    logic [7:0] rcr;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [1:0] cur;
    logic [7:0] cnt;
    logic [STEP_W-1:0] step;
    logic phase;
    logic [PORT_W-1:0] tdata;
    logic tctl;
    logic tclk_prev;
    logic halted;
    logic flush;
  } tpps_state_s;

  tpps_state_s q;
  tpps_state_s d;

  logic tclk_s;
  logic tick;
  logic active;
  logic timed;
  logic [3:0] pats;
  logic [2:0] nxt;
  logic run_end;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [PORT_W-1:0] pat_word;

  // ==========================================================
  // helper functions

  // next enabled pattern after cur in fixed order; msb flags a wrap
  function automatic logic [2:0] next_pat(input logic [3:0] en,
                                          input logic [1:0] cur);
    logic [2:0] res;
    logic [1:0] idx;
    res = {1'b1, cur};
    for (int i = 3; i >= 1; i--) begin
      idx = cur + 2'(i);
      if (en[idx]) res = {(idx <= cur), idx};
    end
    return res;
  endfunction : next_pat

  // byte-lane merge of write data into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = data[8*b +: 8];
    end
    return res;
  endfunction : merge

  // ==========================================================
  // trace clock sampling and pattern word
  tpps_sync #(.W(1)) u_tclk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(traceclkin),
    .sync_out(tclk_s)
  );

  tpps_patgen #(.PORT_W(PORT_W), .STEP_W(STEP_W)) u_patgen (
    .sel(q.cur),
    .step(q.step),
    .phase(q.phase),
    .word(pat_word)
  );

  // rising trace clock edge and generator conditions
  assign tick = tclk_s & ~q.tclk_prev;
  assign timed = q.mode[TIMED_MODE_ENABLE_BIT];
  assign active = q.mode[CONTINUOUS_MODE_ENABLE_BIT] | timed;
  assign pats = q.mode[PAT_W-1:0];
  assign nxt = next_pat(pats, q.cur);
  assign run_end = timed && (nxt[2] || pats == 4'h0);

  // ==========================================================
  // bus handshakes
  assign s_axi_awready = (q.wr == WR_IDLE) || (q.wr == WR_HAVE_DATA);
  assign s_axi_wready = (q.wr == WR_IDLE) || (q.wr == WR_HAVE_ADDR);
  assign s_axi_bvalid = (q.wr == WR_RESP);
  assign s_axi_arready = ~q.rvalid;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign wr_addr = aw_fire ? s_axi_awaddr : q.waddr;
  assign wr_data = w_fire ? s_axi_wdata : q.wdata;
  assign wr_strb = w_fire ? s_axi_wstrb : q.wstrb;
  assign wr_go = (q.wr == WR_IDLE && aw_fire && w_fire)
    || (q.wr == WR_HAVE_ADDR && w_fire)
    || (q.wr == WR_HAVE_DATA && aw_fire);

  // ==========================================================
  // next state of the whole block
  always_comb begin
    logic [31:0] wv;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    wv = 32'h0000_0000;
    ev = '0;
    w1c = '0;
    d = q;
    d.tclk_prev = tclk_s;

    // formatter and flush state tracking
    d.halted = fmt_stopped;
    d.flush = flush_request;
    ev[IRQ_HALTED] = fmt_stopped & ~q.halted;
    ev[IRQ_FLUSH_DONE] = q.flush & flush_ready;

    // pattern generator, one step per rising trace clock edge
    if (tick) begin
      d.tdata = (active && pats != 4'h0) ? pat_word : '0;
      d.tctl = CTL_PRESENT & active;
      if (active) begin
        d.phase = ~q.phase;
        d.step = q.step + STEP_W'(1);
        if (q.cnt <= 8'd1) begin
          if (run_end) begin
            d.mode[TIMED_MODE_ENABLE_BIT] = 1'b0;
            ev[IRQ_TIMED_DONE] = 1'b1;
          end else begin
            d.cur = nxt[1:0];
            d.cnt = q.rcr;
            d.step = '0;
          end
        end else begin
          d.cnt = q.cnt - 8'd1;
        end
      end
    end

    // write channel sequencing
    case (q.wr)
      WR_IDLE: begin
        if (aw_fire && w_fire) d.wr = WR_RESP;
        else if (aw_fire) d.wr = WR_HAVE_ADDR;
        else if (w_fire) d.wr = WR_HAVE_DATA;
      end
      WR_HAVE_ADDR: if (w_fire) d.wr = WR_RESP;
      WR_HAVE_DATA: if (aw_fire) d.wr = WR_RESP;
      WR_RESP: if (s_axi_bready) d.wr = WR_IDLE;
      default: d.wr = WR_IDLE;
    endcase
    if (aw_fire) d.waddr = s_axi_awaddr;
    if (w_fire) begin
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end

    // register writes
    if (wr_go) begin
      d.bresp = RESP_OKAY;
      case (wr_addr)
        OFF_MODE_SELECT: begin
          wv = merge({14'h0000, q.mode}, wr_data, wr_strb);
          d.mode = wv[17:0] & MODE_WRITE_MASK;
          if (wv[CONTINUOUS_MODE_ENABLE_BIT]) begin
            d.mode[TIMED_MODE_ENABLE_BIT] = 1'b0;
          end
          d.cur = 2'(next_pat(wv[PAT_W-1:0], 2'h3));
          d.cnt = q.rcr;
          d.step = '0;
          d.phase = 1'b0;
        end
        OFF_REPEAT_COUNT: begin
          wv = merge({24'h00_0000, q.rcr}, wr_data, wr_strb);
          d.rcr = wv[7:0];
        end
        OFF_IRQ_STATUS: begin
          wv = merge(32'h0000_0000, wr_data, wr_strb);
          w1c = wv[IRQ_W-1:0];
        end
        OFF_IRQ_MASK: begin
          wv = merge({29'h0000_0000, q.irq_mask}, wr_data, wr_strb);
          d.irq_mask = wv[IRQ_W-1:0];
        end
        OFF_FORMATTER_STATUS: d.bresp = RESP_OKAY;
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    // sticky interrupt bits: a new event beats a same-cycle clear
    d.irq_st = (q.irq_st & ~w1c) | ev;

    // register reads
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (ar_fire) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        OFF_MODE_SELECT: d.rdata = {14'h0000, q.mode};
        OFF_REPEAT_COUNT: d.rdata = {24'h00_0000, q.rcr};
        OFF_FORMATTER_STATUS: begin
          d.rdata[CONTROL_PIN_PRESENT_BIT] = CTL_PRESENT;
          d.rdata[FORMATTER_HALTED_BIT] = q.halted;
          d.rdata[FLUSH_ACTIVE_BIT] = q.flush;
        end
        OFF_IRQ_STATUS: d.rdata = {29'h0000_0000, q.irq_st};
        OFF_IRQ_MASK: d.rdata = {29'h0000_0000, q.irq_mask};
        default: d.rresp = RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.wr <= WR_IDLE;
      q.mode <= MODE_RESET;
      q.rcr <= REPEAT_COUNT_RESET;
      q.irq_st <= IRQ_RESET;
      q.irq_mask <= IRQ_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign trace_data = q.tdata;
  assign trace_control_pin = q.tctl;
  assign flush_valid = q.flush;
  // a stopped formatter takes and drops every beat
  assign trace_in_ready = q.halted ? 1'b1 : fmt_in_ready;
  assign fmt_in_valid = trace_in_valid & ~q.halted;
  assign irq = |(q.irq_st & q.irq_mask);

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_mode_exclusive: assert property (
    !(q.mode[CONTINUOUS_MODE_ENABLE_BIT] && timed))
    else $error("continuous and timed mode both set");

  chk_reset_values: assert property (
    $rose(aresetn) |-> q.mode == MODE_RESET && q.rcr == REPEAT_COUNT_RESET)
    else $error("mode or repeat count not zero after reset");

  chk_pattern_enabled: assert property (
    active && pats != 4'h0 && !$past(wr_go) |-> pats[q.cur])
    else $error("running pattern is not enabled");

  chk_timed_off: assert property (
    tick && active && q.cnt <= 8'd1 && run_end && !wr_go
    |=> !timed && q.irq_st[IRQ_TIMED_DONE])
    else $error("timed mode did not end by itself");

  chk_count_reload: assert property (
    tick && active && q.cnt <= 8'd1 && !run_end && !wr_go
    |=> q.cnt == $past(q.rcr) && q.cur == 2'($past(nxt)))
    else $error("counter not reloaded at pattern change");

  chk_count_down: assert property (
    tick && active && q.cnt > 8'd1 && !wr_go
    |=> q.cnt == $past(q.cnt) - 8'd1 && q.cur == $past(q.cur))
    else $error("repeat counter did not step down by one");

  chk_repeat_readback: assert property (
    ar_fire && s_axi_araddr == OFF_REPEAT_COUNT
    |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(q.rcr)})
    else $error("repeat count read differs from programmed value");

  chk_status_read: assert property (
    ar_fire && s_axi_araddr == OFF_FORMATTER_STATUS
    |=> s_axi_rdata[FORMATTER_HALTED_BIT] == $past(q.halted)
    && s_axi_rdata[FLUSH_ACTIVE_BIT] == $past(flush_valid)
    && s_axi_rdata[CONTROL_PIN_PRESENT_BIT] == CTL_PRESENT)
    else $error("status word does not match block state");

  chk_halt_drops: assert property (
    fmt_stopped ##1 fmt_stopped |-> trace_in_ready && !fmt_in_valid)
    else $error("stopped formatter stalls or passes trace data");

  chk_flush_follow: assert property (
    flush_request |=> flush_valid)
    else $error("flush valid did not follow the request");

  cov_timed_done: cover property (tick && active && run_end && q.cnt <= 8'd1);
  cov_all_patterns: cover property (tick && active && pats == 4'hf);
  cov_halted_drop: cover property (q.halted && trace_in_valid);
endmodule : tpps_top
`default_nettype wire

// File: verif/tpps_capture_model.sv
// trace capture model for the far side of the trace port
`timescale 1ns/100ps
`default_nettype none
module tpps_capture_model (
  input wire logic aclk,
  output logic traceclkin,
  input wire logic [31:0] trace_data,
  input wire logic trace_control_pin,
  output logic cap_stb,
  output logic [31:0] cap_word
);
  logic [31:0] last_q;

  // ==========================================================
  // free running trace clock, 160 ns, offset from aclk
  initial begin
    traceclkin = 1'b0;
    #7;
    forever #80 traceclkin = ~traceclkin;
  end

  // a new word counts while framed or nonzero; idle zeros are not words
  always @(posedge aclk) begin
    cap_stb <= (trace_data !== last_q) && (trace_control_pin || trace_data != 0);
    cap_word <= trace_data;
    last_q <= trace_data;
  end
endmodule : tpps_capture_model
`default_nettype wire

// File: verif/tb_tpps_top.sv
// self-checking bench for the trace port pattern and status block
`timescale 1ns/100ps
`default_nettype none
module tb_tpps_top;
  import tpps_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [4:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, trace_data, cap_word;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, trace_in_valid = 1'b0, fmt_in_ready = 1'b1;
  logic fmt_stopped = 1'b0, flush_request = 1'b0, flush_ready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, traceclkin, cap_stb;
  logic trace_control_pin, trace_in_ready, fmt_in_valid, flush_valid, irq;
  logic [33:0] rq[$], tq[$], e;
  logic flip = 1'b0, drain = 1'b0;
  logic [7:0] rnd = 8'h1b;
  int num_errors = 0, compares = 0;

  // 50 MHz clock
  always #10 aclk = ~aclk;

  tpps_top tpps_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .traceclkin(traceclkin),
    .trace_data(trace_data), .trace_control_pin(trace_control_pin),
    .trace_in_valid(trace_in_valid), .trace_in_ready(trace_in_ready),
    .fmt_in_valid(fmt_in_valid), .fmt_in_ready(fmt_in_ready),
    .fmt_stopped(fmt_stopped), .flush_request(flush_request),
    .flush_valid(flush_valid), .flush_ready(flush_ready), .irq(irq));

  tpps_capture_model tpps_capture_model_i (.aclk(aclk),
    .traceclkin(traceclkin), .trace_data(trace_data),
    .trace_control_pin(trace_control_pin), .cap_stb(cap_stb),
    .cap_word(cap_word));

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  // write with both channels offered together, bready held until bvalid
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({32'h0, bresp}, {32'h0, r});
  endtask : wr

  // read; the answer is judged by the watcher below
  task automatic rd(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // note the words of pattern p, n trace cycles; alternating phase is free
  task automatic note_pat(input int p, input int n);
    logic [31:0] w;
    for (int k = 0; k < n; k++) begin
      case (p)
        0: w = 32'h1 << k;
        1: w = ~(32'h1 << k);
        2: w = k[0] ? 32'h5555_5555 : 32'haaaa_aaaa;
        default: w = k[0] ? 32'h0 : 32'hffff_ffff;
      endcase
      tq.push_back({p > 1 && k == 0, p > 1, w});
    end
  endtask : note_pat

  task automatic wait_queue(input int left);
    for (int i = 0; i < 4000 && tq.size() > left; i++) @(posedge aclk);
  endtask : wait_queue

  // ==========================================================
  // watchers: oldest note against each read answer and captured word
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
      chk({rresp, rdata}, rq.pop_front());
    if (cap_stb === 1'b1 && tq.size() > 0) begin
      e = tq.pop_front();
      if (e[33]) flip = (cap_word === ~e[31:0]);
      chk({2'b0, cap_word}, {2'b0, e[31:0] ^ {32{flip & e[32]}}});
    end else if (cap_stb === 1'b1 && !drain) begin
      chk({2'b0, cap_word}, 34'h0);
    end
  end

  // watchdog far beyond the expected run time
  initial begin
    #200us;
    num_errors++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_MODE_SELECT, 32'h0, RESP_OKAY);
    rd(OFF_REPEAT_COUNT, 32'h0, RESP_OKAY);
    wr(OFF_FORMATTER_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(OFF_FORMATTER_STATUS, 32'h4, RESP_OKAY);
    rd(5'h14, 32'h0, RESP_SLVERR);
    wr(5'h14, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    $display("test reset_values done");
    // random start values, then a write on an unused byte lane
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr_next(rnd);
      wr(OFF_REPEAT_COUNT, {24'hff_ffff, rnd}, 4'hf, RESP_OKAY);
      rd(OFF_REPEAT_COUNT, {24'h0, rnd}, RESP_OKAY);
    end
    wr(OFF_REPEAT_COUNT, 32'h0000_3333, 4'h2, RESP_OKAY);
    rd(OFF_REPEAT_COUNT, {24'h0, rnd}, RESP_OKAY);
    $display("test repeat_count done");
    // timed run of all four patterns, three trace cycles each
    wr(OFF_REPEAT_COUNT, 32'h3, 4'hf, RESP_OKAY);
    for (int p = 0; p < 4; p++) note_pat(p, 3);
    wr(OFF_MODE_SELECT, 32'h0001_000f, 4'hf, RESP_OKAY);
    wait_queue(0);
    repeat (4) @(posedge aclk);
    chk(34'(tq.size()), 34'h0);
    rd(OFF_MODE_SELECT, 32'h0000_000f, RESP_OKAY);
    // timed mode with no pattern ends on its third trace edge, after the repeat count of three
    wr(OFF_MODE_SELECT, 32'h0001_0000, 4'hf, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rd(OFF_MODE_SELECT, 32'h0000_0000, RESP_OKAY);
    $display("test timed_mode done");
    // both mode bits: continuous only, and it keeps running
    wr(OFF_REPEAT_COUNT, 32'h1, 4'hf, RESP_OKAY);
    for (int i = 0; i < 15; i++) begin
      note_pat(0, 1);
      note_pat(1, 1);
    end
    wr(OFF_MODE_SELECT, 32'h0003_0003, 4'hf, RESP_OKAY);
    rd(OFF_MODE_SELECT, 32'h0002_0003, RESP_OKAY);
    wait_queue(8);
    rd(OFF_MODE_SELECT, 32'h0002_0003, RESP_OKAY);
    drain = 1'b1;
    wr(OFF_MODE_SELECT, 32'h0, 4'hf, RESP_OKAY);
    repeat (40) @(posedge aclk);
    tq.delete();
    drain = 1'b0;
    $display("test continuous_mode done");
    // stopped formatter, flush, interrupts
    @(posedge aclk);
    fmt_stopped <= 1'b1;
    fmt_in_ready <= 1'b0;
    trace_in_valid <= 1'b1;
    flush_request <= 1'b1;
    repeat (2) @(negedge aclk);
    chk({33'h0, trace_in_ready}, 34'h1);
    chk({33'h0, fmt_in_valid}, 34'h0);
    chk({33'h0, flush_valid}, 34'h1);
    rd(OFF_FORMATTER_STATUS, 32'h7, RESP_OKAY);
    @(posedge aclk);
    flush_ready <= 1'b1;
    @(posedge aclk);
    flush_ready <= 1'b0;
    flush_request <= 1'b0;
    fmt_stopped <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(OFF_FORMATTER_STATUS, 32'h4, RESP_OKAY);
    rd(OFF_IRQ_STATUS, 32'h7, RESP_OKAY);
    @(negedge aclk);
    chk({33'h0, irq}, 34'h0);
    wr(OFF_IRQ_MASK, 32'h4, 4'hf, RESP_OKAY);
    @(negedge aclk);
    chk({33'h0, irq}, 34'h1);
    rd(OFF_IRQ_MASK, 32'h4, RESP_OKAY);
    wr(OFF_IRQ_STATUS, 32'h4, 4'hf, RESP_OKAY);
    @(negedge aclk);
    chk({33'h0, irq}, 34'h0);
    rd(OFF_IRQ_STATUS, 32'h3, RESP_OKAY);
    $display("test status_and_irq done");
    repeat (4) @(posedge aclk);
    chk(34'(rq.size()), 34'h0);
    complete_run();
  end
endmodule : tb_tpps_top
`default_nettype wire
